// [rtl/cmd_decoder_pkg.sv]
/*
  Package for the serial motor command decoder: command codes, framing
  bytes, limits and the output carrier struct.
  Assumes bytes arrive already deframed from a UART, one per strobe.
*/
package cmd_decoder_pkg;
  localparam logic [7:0]  LEAD_ADDRESSED = 8'haa;
  localparam logic [7:0]  LEAD_SERVO     = 8'hff;
  localparam logic [7:0]  SERVO_BCAST    = 8'hfe;
  localparam logic [7:0]  SERVO_STOP     = 8'h7f;
  localparam logic [6:0]  DEV_NUM_RESET  = 7'h0d;
  localparam logic [6:0]  OP_EXIT_LOCK   = 7'h03;
  localparam logic [6:0]  OP_FWD_FULL    = 7'h05;
  localparam logic [6:0]  OP_REV_FULL    = 7'h06;
  localparam logic [6:0]  OP_FWD_7BIT    = 7'h09;
  localparam logic [6:0]  OP_REV_7BIT    = 7'h0a;
  localparam logic [6:0]  OP_BRAKE       = 7'h12;
  localparam logic [11:0] SPEED_FULL     = 12'hc80;
  localparam logic [6:0]  BRAKE_FULL     = 7'h20;
  localparam int          SPEED_LO_BITS  = 5;

  typedef struct packed {
    logic        reverse;
    logic [11:0] speed;
    logic        brake_en;
    logic [5:0]  brake_amount;
  } drive_cmd_s;
endpackage : cmd_decoder_pkg

// [rtl/speed_scale.sv]
/*
  Scales a 7-bit speed (0..127) to the full 0..3200 range.
  Pure combinational; assumes the caller has range-checked the input.
*/
`timescale 1ns/100ps
`default_nettype none
module speed_scale (
  input  wire logic [6:0]  speed7,
  output logic      [11:0] speed12
);
  logic [18:0] prod;
  // multiply then divide keeps 127 exactly at full speed
  assign prod    = 19'(speed7) * 19'(cmd_decoder_pkg::SPEED_FULL);
  assign speed12 = 12'(prod / 19'd127);
endmodule : speed_scale
`default_nettype wire

// [rtl/motor_serial_command_decoder.sv]
/*
  Binary serial command decoder for a DC motor controller: compact,
  addressed and three-byte servo framing; drives target speed,
  direction and brake duty.
  Assumes rx_valid pulses once per received byte, synchronous to ref_clk.
*/
// What this block does
// - serial mode with interlock armed: motor held stopped until exit command 0x83/0x03
// - interlock re-armed at reset and whenever an error stops the motor
// - interlock applies only when not disabled by configuration
// - forward full-resolution 0x85/0x05 sets forward speed 0..3200
// - first data byte low five speed bits, second byte high seven bits
// - reverse full-resolution 0x86/0x06 like forward, opposite direction
// - forward 7-bit 0x89/0x09 sets speed from one byte 0..127
// - reverse 7-bit 0x8a/0x0a sets reverse speed from one byte 0..127
// - three-byte servo packet 0xff, device number, speed byte sets speed
// - brake 0x92/0x12 brakes at once, bypassing deceleration limit
// - brake amount 0..32: 0 coasting, 32 full braking
// - brake amount above 32 raises serial format error, no change
// - commands act only in serial mode and send no response
// - addressed framing: 0xaa, device number, command with top bit clear, data
// - addressed packet acted on only if device number matches, default 0x0d
// - servo speed byte offset by 127: 0 full reverse, 127 stop, 254 full forward
// - servo packet with device number 254 is broadcast and accepted
`timescale 1ns/100ps
`default_nettype none
module motor_serial_command_decoder (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             rx_valid,
  input  wire logic [7:0]                       rx_byte,
  input  wire logic                             serial_mode,
  input  wire logic                             interlock_disable,
  input  wire logic [6:0]                       device_number,
  input  wire logic                             error_stop,
  output cmd_decoder_pkg::drive_cmd_s           drive_q,
  output logic                                  interlock_armed_q,
  output logic                                  format_error_q
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_OP    = 3'b011,
    ST_DATA  = 3'b010,
    ST_SADDR = 3'b110,
    ST_SSPD  = 3'b111
  } state_e;

  state_e      state_q;
  logic [6:0]  op_q;
  logic [6:0]  data0_q;
  logic        data_cnt_q;
  logic        servo_hit_q;
  cmd_decoder_pkg::drive_cmd_s target_q;

  logic        need_two;
  logic        is_cmd;
  logic        cmd_done;
  logic [11:0] full_speed;
  logic [11:0] scaled7;
  logic [6:0]  servo_mag;
  logic [11:0] servo_scaled;
  logic        known_op;

  // top-bit-set bytes restart framing except inside a servo packet
  assign is_cmd     = rx_valid && rx_byte[7];
  assign need_two   = (op_q == cmd_decoder_pkg::OP_FWD_FULL) ||
                      (op_q == cmd_decoder_pkg::OP_REV_FULL);
  assign full_speed = {rx_byte[6:0], data0_q[4:0]};
  assign known_op   = (rx_byte[6:0] == cmd_decoder_pkg::OP_EXIT_LOCK) ||
                      (rx_byte[6:0] == cmd_decoder_pkg::OP_FWD_FULL) ||
                      (rx_byte[6:0] == cmd_decoder_pkg::OP_REV_FULL) ||
                      (rx_byte[6:0] == cmd_decoder_pkg::OP_FWD_7BIT) ||
                      (rx_byte[6:0] == cmd_decoder_pkg::OP_REV_7BIT) ||
                      (rx_byte[6:0] == cmd_decoder_pkg::OP_BRAKE);
  // servo magnitude from offset-127 byte
  assign servo_mag  = rx_byte >= cmd_decoder_pkg::SERVO_STOP ?
                      7'(rx_byte - cmd_decoder_pkg::SERVO_STOP) :
                      7'(cmd_decoder_pkg::SERVO_STOP - rx_byte);

  speed_scale u_scale7 (
    .speed7  (rx_byte[6:0]),
    .speed12 (scaled7)
  );
  speed_scale u_scale_servo (
    .speed7  (servo_mag),
    .speed12 (servo_scaled)
  );

  // framing state machine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      op_q        <= 7'h00;
      data0_q     <= 7'h00;
      data_cnt_q  <= 1'b0;
      servo_hit_q <= 1'b0;
    end else if (rx_valid) begin
      case (state_q)
        ST_SADDR: begin
          // servo bytes may have the top bit set, except 0xff itself
          if (rx_byte == cmd_decoder_pkg::LEAD_SERVO) begin
            state_q <= ST_SADDR;
          end else begin
            servo_hit_q <= (rx_byte == {1'b0, device_number}) ||
                           (rx_byte == cmd_decoder_pkg::SERVO_BCAST);
            state_q     <= ST_SSPD;
          end
        end
        ST_SSPD: begin
          state_q <= (rx_byte == cmd_decoder_pkg::LEAD_SERVO) ? ST_SADDR : ST_IDLE;
        end
        default: begin
          if (rx_byte == cmd_decoder_pkg::LEAD_SERVO) begin
            state_q <= ST_SADDR;
          end else if (rx_byte == cmd_decoder_pkg::LEAD_ADDRESSED) begin
            state_q <= ST_ADDR;
          end else if (rx_byte[7]) begin
            op_q       <= rx_byte[6:0];
            data_cnt_q <= 1'b0;
            state_q    <= known_op ? (rx_byte[6:0] == cmd_decoder_pkg::OP_EXIT_LOCK ?
                          ST_IDLE : ST_DATA) : ST_IDLE;
          end else begin
            case (state_q)
              ST_ADDR: begin
                // mismatched device number drops the packet
                state_q <= (rx_byte[6:0] == device_number) ? ST_OP : ST_IDLE;
              end
              ST_OP: begin
                op_q       <= rx_byte[6:0];
                data_cnt_q <= 1'b0;
                state_q    <= (known_op && rx_byte[6:0] != cmd_decoder_pkg::OP_EXIT_LOCK) ?
                              ST_DATA : ST_IDLE;
              end
              ST_DATA: begin
                data0_q    <= rx_byte[6:0];
                data_cnt_q <= 1'b1;
                state_q    <= (need_two && !data_cnt_q) ? ST_DATA : ST_IDLE;
              end
              default: state_q <= ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // a command completes on its last data byte
  always_comb begin
    cmd_done = 1'b0;
    if (rx_valid && !rx_byte[7] && state_q == ST_DATA) begin
      cmd_done = !need_two || data_cnt_q;
    end
  end

  logic exit_now;
  assign exit_now = rx_valid && !rx_byte[7] && state_q == ST_OP &&
                    rx_byte[6:0] == cmd_decoder_pkg::OP_EXIT_LOCK ||
                    is_cmd && state_q != ST_SADDR && state_q != ST_SSPD &&
                    rx_byte[6:0] == cmd_decoder_pkg::OP_EXIT_LOCK;

  // target update; every path leaves target alone on error
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      target_q       <= '0;
      format_error_q <= 1'b0;
    end else begin
      format_error_q <= 1'b0;
      if (serial_mode && cmd_done) begin
        case (op_q)
          cmd_decoder_pkg::OP_FWD_FULL, cmd_decoder_pkg::OP_REV_FULL: begin
            if (full_speed > cmd_decoder_pkg::SPEED_FULL) begin
              format_error_q <= 1'b1;
            end else begin
              target_q.speed    <= full_speed;
              target_q.reverse  <= (op_q == cmd_decoder_pkg::OP_REV_FULL);
              target_q.brake_en <= 1'b0;
            end
          end
          cmd_decoder_pkg::OP_FWD_7BIT, cmd_decoder_pkg::OP_REV_7BIT: begin
            target_q.speed    <= scaled7;
            target_q.reverse  <= (op_q == cmd_decoder_pkg::OP_REV_7BIT);
            target_q.brake_en <= 1'b0;
          end
          cmd_decoder_pkg::OP_BRAKE: begin
            if (rx_byte[6:0] > cmd_decoder_pkg::BRAKE_FULL) begin
              format_error_q <= 1'b1;
            end else begin
              target_q.brake_en     <= 1'b1;
              target_q.brake_amount <= 6'(rx_byte[6:0]);
              target_q.speed        <= 12'h000;
            end
          end
          default: target_q <= target_q;
        endcase
      end else if (serial_mode && rx_valid && state_q == ST_SSPD && servo_hit_q &&
                   rx_byte != cmd_decoder_pkg::LEAD_SERVO) begin
        target_q.speed    <= servo_scaled;
        target_q.reverse  <= (rx_byte < cmd_decoder_pkg::SERVO_STOP);
        target_q.brake_en <= 1'b0;
      end
    end
  end

  // interlock arms at reset and on error stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interlock_armed_q <= 1'b1;
    end else if (error_stop) begin
      interlock_armed_q <= 1'b1;
    end else if (serial_mode && exit_now) begin
      interlock_armed_q <= 1'b0;
    end
  end

  // hold motor stopped while interlock applies
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_q <= '0;
    end else if (!serial_mode || (interlock_armed_q && !interlock_disable)) begin
      drive_q <= '0;
    end else begin
      drive_q <= target_q;
    end
  end
endmodule : motor_serial_command_decoder
`default_nettype wire

// [testbench/host_byte_source.sv]
/* host model: sends command packets as back-to-back rx_valid strobes.
   assumes the caller sits just after a ref_clk rising edge. */
`timescale 1ns/100ps
`default_nettype none
module host_byte_source (
  input  wire logic       ref_clk,
  output logic            rx_valid,
  output logic      [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // first byte sits in the top of p
  task automatic send(input int n, input logic [39:0] p);
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_byte  = p[39-8*i -: 8];
      @(posedge ref_clk);
      #1;
    end
    // released line shows no stale byte
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask : send
endmodule : host_byte_source
`default_nettype wire

// [testbench/motor_cmd_monitor.sv]
/* port checker for the serial motor command decoder.
   assumes it is bound into the decoder and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module motor_cmd_monitor (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        interlock_disable,
  input wire logic                        error_stop,
  input wire cmd_decoder_pkg::drive_cmd_s drive_q,
  input wire logic                        interlock_armed_q,
  input wire logic                        format_error_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_reset_armed: assert property (
    $past(rst) |-> interlock_armed_q && drive_q.speed == 12'h000) else $error("bad reset state");
  a_error_rearm: assert property (
    error_stop && !interlock_disable |-> ##[1:2] interlock_armed_q) else $error("no re-arm");
  // two cycles so the registered output has caught up with the interlock
  a_armed_stop: assert property (
    (interlock_armed_q && !interlock_disable)[*2] |-> drive_q.speed == 12'h000)
    else $error("motor runs while armed");
  a_speed_max: assert property (drive_q.speed <= 12'hc80) else $error("speed over full");
  a_brake_max: assert property (drive_q.brake_amount <= 6'h20) else $error("brake over 32");
  a_brake_still: assert property (
    drive_q.brake_en |-> drive_q.speed == 12'h000) else $error("speed during brake");
  a_err_pulse: assert property (format_error_q |=> !format_error_q) else $error("long error");
  a_err_hold: assert property (
    format_error_q && !error_stop |=> $stable(drive_q)) else $error("change on error");
endmodule : motor_cmd_monitor
bind motor_serial_command_decoder motor_cmd_monitor motor_cmd_monitor_i (
  .ref_clk(ref_clk), .rst(rst), .interlock_disable(interlock_disable), .error_stop(error_stop),
  .drive_q(drive_q), .interlock_armed_q(interlock_armed_q), .format_error_q(format_error_q));
`default_nettype wire

// [testbench/motor_serial_command_decoder_tb.sv]
/* directed testbench for the serial motor command decoder.
   assumes the host model and the bound port checker alongside. */
`timescale 1ns/100ps
`default_nettype none
module motor_serial_command_decoder_tb;
  logic                        ref_clk;
  logic                        rst;
  logic                        serial_mode;
  logic                        interlock_disable;
  logic                        error_stop;
  logic                        rx_valid;
  logic [7:0]                  rx_byte;
  cmd_decoder_pkg::drive_cmd_s drive_q;
  int                          miscompares = 0;
  int                          num_checks = 0;
  int                          err_seen = 0;
  int                          err_exp = 0;
  logic                        fe;
  logic                        armed;
  host_byte_source h_i (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  motor_serial_command_decoder motor_serial_command_decoder_i (
    .ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .serial_mode(serial_mode), .interlock_disable(interlock_disable),
    .device_number(7'h0d), .error_stop(error_stop), .drive_q(drive_q),
    .interlock_armed_q(armed), .format_error_q(fe));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // counted at the falling edge, well away from the register updates
  always @(negedge ref_clk) if (fe === 1'b1) err_seen++;
  task stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // reverse is left open while braking
  task chk(input cmd_decoder_pkg::drive_cmd_s e);
    repeat (3) @(posedge ref_clk);
    #1;
    num_checks++;
    if (drive_q.speed !== e.speed || drive_q.brake_en !== e.brake_en
        || drive_q.brake_amount !== e.brake_amount || err_seen != err_exp
        || (!e.brake_en && drive_q.reverse !== e.reverse)) begin
      miscompares++;
      $display("unexpected at %0t: drive %h error count %0d", $time, drive_q, err_seen);
    end
  endtask : chk
  task t_lock;
    h_i.send(3, 40'h8500640000);
    chk('{1'b0, 12'h000, 1'b0, 6'h00});
    num_checks++;
    if (armed !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: interlock not armed after reset", $time);
    end
    h_i.send(1, 40'h8300000000);
    chk('{1'b0, 12'hc80, 1'b0, 6'h00});
    num_checks++;
    if (armed !== 1'b0) begin
      miscompares++;
      $display("unexpected at %0t: interlock still armed after exit", $time);
    end
    $display("done lock");
  endtask : t_lock
  task t_full;
    h_i.send(3, 40'h8612260000);
    chk('{1'b1, 12'h4d2, 1'b0, 6'h00});
    h_i.send(5, 40'haa0c050010);
    chk('{1'b1, 12'h4d2, 1'b0, 6'h00});
    h_i.send(5, 40'haa0d050010);
    chk('{1'b0, 12'h200, 1'b0, 6'h00});
    h_i.send(2, 40'h897f000000);
    chk('{1'b0, 12'hc80, 1'b0, 6'h00});
    h_i.send(4, 40'haa0d0a3f00);
    chk('{1'b1, 12'h633, 1'b0, 6'h00});
    $display("done speed");
  endtask : t_full
  task t_servo;
    h_i.send(3, 40'hff0dbe0000);
    chk('{1'b0, 12'h633, 1'b0, 6'h00});
    h_i.send(3, 40'hfffe000000);
    chk('{1'b1, 12'hc80, 1'b0, 6'h00});
    h_i.send(3, 40'hff0c7f0000);
    chk('{1'b1, 12'hc80, 1'b0, 6'h00});
    $display("done servo");
  endtask : t_servo
  task t_brake;
    h_i.send(2, 40'h9210000000);
    chk('{1'b0, 12'h000, 1'b1, 6'h10});
    h_i.send(2, 40'h9221000000);
    err_exp++;
    chk('{1'b0, 12'h000, 1'b1, 6'h10});
    h_i.send(4, 40'haa0d122000);
    chk('{1'b0, 12'h000, 1'b1, 6'h20});
    h_i.send(3, 40'h8501640000);
    err_exp++;
    chk('{1'b0, 12'h000, 1'b1, 6'h20});
    h_i.send(3, 40'h851f630000);
    // last brake amount is kept while the brake is off
    chk('{1'b0, 12'hc7f, 1'b0, 6'h20});
    $display("done brake");
  endtask : t_brake
  task t_mode;
    serial_mode = 1'b0;
    h_i.send(2, 40'h890a000000);
    // drive output is zeroed outside serial mode
    chk('{1'b0, 12'h000, 1'b0, 6'h00});
    serial_mode = 1'b1;
    chk('{1'b0, 12'hc7f, 1'b0, 6'h20});
    error_stop = 1'b1;
    @(posedge ref_clk);
    #1;
    error_stop = 1'b0;
    h_i.send(2, 40'h8940000000);
    chk('{1'b0, 12'h000, 1'b0, 6'h00});
    interlock_disable = 1'b1;
    chk('{1'b0, 12'h64c, 1'b0, 6'h20});
    $display("done mode");
  endtask : t_mode
  initial begin
    rst = 1'b1;
    serial_mode = 1'b1;
    interlock_disable = 1'b0;
    error_stop = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_lock();
    t_full();
    t_servo();
    t_brake();
    t_mode();
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
endmodule : motor_serial_command_decoder_tb
`default_nettype wire
